// ### lds_top.sv
// link diagnostic flag block: receive checkers, idle insertion, reset sequencer, registers
`include "lds_map.svh"
module lds_top #(
    parameter int NFUNC = 1
) (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic [`LDS_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic [31:0]                 reg_rdata,
    output logic                        irq,
    input  wire logic                   xcvr_ready,
    output logic                        reset_sequence_complete,
    input  wire lds_pkg::lds_rx_sym_t   rx_sym [NFUNC],
    input  wire logic [NFUNC-1:0]       rm_overflow_evt,
    output logic [NFUNC-1:0]            rate_match_overflow,
    output logic [NFUNC-1:0]            bad_packet_end_seen,
    output logic [NFUNC-1:0]            mgmt_parity_error,
    output logic [NFUNC-1:0]            rx_checksum_error,
    output logic [NFUNC-1:0]            unexpected_flow_msg,
    output logic [NFUNC-1:0]            unexpected_retry_msg,
    output logic [NFUNC-1:0]            invalid_mgmt_packet,
    output logic [NFUNC-1:0]            missing_start_word,
    output logic [NFUNC-1:0]            addr_conflict,
    output logic [NFUNC-1:0]            seg_error,
    output logic                        link_restart,
    input  wire logic                   tx_rd_req,
    input  wire logic                   tx_empty,
    input  wire logic [31:0]            tx_data_in,
    output logic [31:0]                 tx_word,
    output logic                        tx_word_is_idle,
    output logic                        rate_match_underflow
);
    localparam logic [`LDS_CNT_W-1:0] RST_LAST = `LDS_CNT_W'(`LDS_RST_WAIT_CYC - 1);

    lds_pkg::lds_rx_flags_t          fl [NFUNC];
    logic [NFUNC-1:0]                restart_req;
    logic [`LDS_CTRL_W-1:0]          ctrl;
    logic [`LDS_CTRL_W-1:0]          next_ctrl;
    logic [`LDS_EV_W-1:0]            evt;
    logic [`LDS_EV_W-1:0]            next_evt;
    logic [`LDS_EV_W-1:0]            mask;
    logic [`LDS_EV_W-1:0]            next_mask;
    logic [`LDS_EV_W-1:0]            ev_in;
    logic [`LDS_EV_W-1:0]            ev_clr;
    logic [31:0]                     next_rdata;
    logic                            rdy_s1;
    logic                            rdy_s2;
    lds_pkg::lds_rst_state_t         rs_state;
    lds_pkg::lds_rst_state_t         next_rs_state;
    logic [`LDS_CNT_W-1:0]           rs_cnt;
    logic [`LDS_CNT_W-1:0]           next_rs_cnt;
    logic                            next_done;
    logic                            next_restart;
    logic [31:0]                     next_tx_word;
    logic                            next_tx_idle;
    logic                            next_unf;

    // one checker per receiver function keeps broadcast flags apart
    for (genvar i = 0; i < NFUNC; i++) begin : g_fn
        lds_rx_check u_chk (
            .clk             (clk),
            .rst_b           (rst_b),
            .sym             (rx_sym[i]),
            .rm_overflow_evt (rm_overflow_evt[i]),
            .flow_en         (ctrl[`LDS_CTRL_FLOW]),
            .retry_en        (ctrl[`LDS_CTRL_RETRY]),
            .flags           (fl[i]),
            .seg_error       (seg_error[i]),
            .link_restart    (restart_req[i])
        );
        assign rate_match_overflow[i]  = fl[i].ovf;
        assign bad_packet_end_seen[i]  = fl[i].ebp;
        assign mgmt_parity_error[i]    = fl[i].bip;
        assign rx_checksum_error[i]    = fl[i].crc;
        assign unexpected_flow_msg[i]  = fl[i].ufc;
        assign unexpected_retry_msg[i] = fl[i].uro;
        assign invalid_mgmt_packet[i]  = fl[i].inv;
        assign missing_start_word[i]   = fl[i].msw;
        assign addr_conflict[i]        = fl[i].adr;
    end

    // transceiver ready comes from another clock: two flops first
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdy_s1 <= 1'b0;
            rdy_s2 <= 1'b0;
        end else begin
            rdy_s1 <= xcvr_ready;
            rdy_s2 <= rdy_s1;
        end
    end

    // reset sequencer: settle wait, then ready; a lost ready reruns it
    always_comb begin
        next_rs_state = rs_state;
        next_rs_cnt   = rs_cnt;
        case (rs_state)
            lds_pkg::RS_COUNT: begin
                if (rs_cnt == RST_LAST) begin
                    next_rs_state = lds_pkg::RS_WAIT;
                    next_rs_cnt   = '0;
                end else begin
                    next_rs_cnt = rs_cnt + `LDS_CNT_W'(1);
                end
            end
            lds_pkg::RS_WAIT: begin
                if (rdy_s2) begin
                    next_rs_state = lds_pkg::RS_DONE;
                end
            end
            lds_pkg::RS_DONE: begin
                if (!rdy_s2) begin
                    next_rs_state = lds_pkg::RS_COUNT;
                end
            end
            default: begin
                next_rs_state = lds_pkg::RS_COUNT;
                next_rs_cnt   = '0;
            end
        endcase
        next_done = (next_rs_state == lds_pkg::RS_DONE);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rs_state                <= lds_pkg::RS_COUNT;
            rs_cnt                  <= '0;
            reset_sequence_complete <= 1'b0;
        end else begin
            rs_state                <= next_rs_state;
            rs_cnt                  <= next_rs_cnt;
            reset_sequence_complete <= next_done;
        end
    end

    // transmit side: an empty buffer on a read sends idle, link stays up
    always_comb begin
        next_tx_word = tx_word;
        next_tx_idle = tx_word_is_idle;
        next_unf     = 1'b0;
        if (tx_rd_req) begin
            next_unf     = tx_empty;
            next_tx_idle = tx_empty;
            next_tx_word = tx_empty ? `LDS_IDLE_WORD : tx_data_in;
        end
        next_restart = |restart_req;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_word              <= `LDS_IDLE_WORD;
            tx_word_is_idle      <= 1'b1;
            rate_match_underflow <= 1'b0;
            link_restart         <= 1'b0;
        end else begin
            tx_word              <= next_tx_word;
            tx_word_is_idle      <= next_tx_idle;
            rate_match_underflow <= next_unf;
            link_restart         <= next_restart;
        end
    end

    // register file; sticky events, set beats a same-cycle clear
    always_comb begin
        ev_in                = '0;
        ev_in[`LDS_EV_OVF]   = |rate_match_overflow;
        ev_in[`LDS_EV_UNF]   = rate_match_underflow;
        ev_in[`LDS_EV_EBP]   = |bad_packet_end_seen;
        ev_in[`LDS_EV_BIP]   = |mgmt_parity_error;
        ev_in[`LDS_EV_CRC]   = |rx_checksum_error;
        ev_in[`LDS_EV_UFC]   = |unexpected_flow_msg;
        ev_in[`LDS_EV_URO]   = |unexpected_retry_msg;
        ev_in[`LDS_EV_INV]   = |invalid_mgmt_packet;
        ev_in[`LDS_EV_MSW]   = |missing_start_word;
        ev_in[`LDS_EV_ADR]   = |addr_conflict;
        ev_in[`LDS_EV_DONE]  = next_done && !reset_sequence_complete;
        ev_clr               = '0;
        next_ctrl            = ctrl;
        next_mask            = mask;
        if (reg_wr) begin
            case (reg_addr)
                `LDS_OFF_CTRL: next_ctrl = reg_wdata[`LDS_CTRL_W-1:0];
                `LDS_OFF_EVT:  ev_clr    = reg_wdata[`LDS_EV_W-1:0];
                `LDS_OFF_MASK: next_mask = reg_wdata[`LDS_EV_W-1:0];
                default: begin
                end
            endcase
        end
        next_evt   = (evt & ~ev_clr) | ev_in;
        next_rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `LDS_OFF_CTRL: next_rdata = {{(32-`LDS_CTRL_W){1'b0}}, ctrl};
                `LDS_OFF_EVT:  next_rdata = {{(32-`LDS_EV_W){1'b0}}, evt};
                `LDS_OFF_MASK: next_rdata = {{(32-`LDS_EV_W){1'b0}}, mask};
                `LDS_OFF_STAT: next_rdata = {29'h0000_0000, rs_state, reset_sequence_complete};
                default:       next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl      <= `LDS_CTRL_RST;
            evt       <= `LDS_EV_RST;
            mask      <= `LDS_EV_RST;
            reg_rdata <= 32'h0000_0000;
        end else begin
            ctrl      <= next_ctrl;
            evt       <= next_evt;
            mask      <= next_mask;
            reg_rdata <= next_rdata;
        end
    end

    assign irq = |(evt & mask);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_DONE_NEEDS_READY: assert property ($rose(reset_sequence_complete) |-> $past(rdy_s2))
        else $error("reset complete without transceiver ready");
    AST_DONE_DROPS: assert property (reset_sequence_complete && !rdy_s2
        |=> !reset_sequence_complete)
        else $error("reset complete held after ready lost");
    AST_UNF_IDLE: assert property (tx_rd_req && tx_empty |=> rate_match_underflow
        && tx_word == `LDS_IDLE_WORD && tx_word_is_idle)
        else $error("underflow did not insert idle");
    AST_UNF_NO_RESTART: assert property (rate_match_underflow && !$past(|restart_req)
        |-> !link_restart)
        else $error("underflow restarted the link");
    AST_RESTART: assert property ((|rm_overflow_evt) |=> ##1 link_restart)
        else $error("overflow did not restart link");
    AST_EVT_STICKY: assert property (rate_match_underflow |=> evt[`LDS_EV_UNF])
        else $error("event set lost against clear");

    COV_UNF: cover property (rate_match_underflow);
    COV_DONE: cover property ($rose(reset_sequence_complete));
endmodule

// ### lds_map.svh
// register map, field positions and timing counts of the link diagnostic flag block
// Function
// - raise reset-sequence-complete once the transceiver reset sequence has finished
// - rate-match overflow raises its flag and restarts the link
// - rate-match underflow raises its flag, link stays up, idles are inserted
// - an end-of-bad-packet character raises the bad-packet-end flag
// - failed 8-bit interleaved parity of a management packet raises its flag
// - failed checksum of a received segment or packet raises its flag
// - flow message while flow control is disabled raises its flag
// - retry message while retry-on-error is disabled raises its flag
// - management packet of undefined type raises the invalid packet flag
// - data without a preceding start word raises the missing-start flag
// - start and end address differ: raise conflict flag, mark segment errored
// - broadcast mode keeps one set of receive flags per receiver function
`ifndef LDS_MAP_SVH
`define LDS_MAP_SVH

`define LDS_ADDR_W       4
`define LDS_OFF_CTRL     4'h0
`define LDS_OFF_EVT      4'h4
`define LDS_OFF_MASK     4'h8
`define LDS_OFF_STAT     4'hC

`define LDS_CTRL_W       2
`define LDS_CTRL_RST     2'h0
`define LDS_CTRL_FLOW    0
`define LDS_CTRL_RETRY   1

`define LDS_EV_W         11
`define LDS_EV_RST       11'h000
`define LDS_EV_OVF       0
`define LDS_EV_UNF       1
`define LDS_EV_EBP       2
`define LDS_EV_BIP       3
`define LDS_EV_CRC       4
`define LDS_EV_UFC       5
`define LDS_EV_URO       6
`define LDS_EV_INV       7
`define LDS_EV_MSW       8
`define LDS_EV_ADR       9
`define LDS_EV_DONE      10

`define LDS_CLK_MHZ      125
`define LDS_RST_WAIT_NS  1000
`define LDS_RST_WAIT_CYC (((`LDS_RST_WAIT_NS * `LDS_CLK_MHZ) + 999) / 1000)
`define LDS_CNT_W        16
`define LDS_IDLE_WORD    32'hBCBCBCBC

`endif

// ### lds_pkg.sv
// types and helpers shared by the link diagnostic flag block
package lds_pkg;

    typedef enum logic [2:0] {
        K_IDLE = 3'h0,
        K_SOW  = 3'h1,
        K_DATA = 3'h2,
        K_EOP  = 3'h3,
        K_EBP  = 3'h4,
        K_MGMT = 3'h5
    } lds_kind_t;

    typedef enum logic [3:0] {
        MG_FC   = 4'h0,
        MG_ACK  = 4'h1,
        MG_NACK = 4'h2
    } lds_mgmt_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'h0,
        ST_PKT  = 1'h1
    } lds_rx_state_t;

    typedef enum logic [1:0] {
        RS_COUNT = 2'h0,
        RS_WAIT  = 2'h1,
        RS_DONE  = 2'h2
    } lds_rst_state_t;

    typedef struct packed {
        logic        valid;
        lds_kind_t   kind;
        logic [7:0]  addr;
        logic [31:0] data;
        logic [7:0]  chk;
        logic        crc_ok;
    } lds_rx_sym_t;

    typedef struct packed {
        logic ovf;
        logic ebp;
        logic bip;
        logic crc;
        logic ufc;
        logic uro;
        logic inv;
        logic msw;
        logic adr;
    } lds_rx_flags_t;

    function automatic logic [7:0] lds_bip8(input logic [31:0] d);
        lds_bip8 = d[31:24] ^ d[23:16] ^ d[15:8] ^ d[7:0];
    endfunction

endpackage

// ### lds_rx_check.sv
// receive-side checker for one receiver function
module lds_rx_check (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire lds_pkg::lds_rx_sym_t   sym,
    input  wire logic                   rm_overflow_evt,
    input  wire logic                   flow_en,
    input  wire logic                   retry_en,
    output lds_pkg::lds_rx_flags_t      flags,
    output logic                        seg_error,
    output logic                        link_restart
);
    lds_pkg::lds_rx_state_t state;
    lds_pkg::lds_rx_state_t next_state;
    logic [7:0]             start_addr;
    logic [7:0]             next_start_addr;
    lds_pkg::lds_rx_flags_t next_flags;
    logic                   next_seg_error;
    logic                   next_link_restart;
    logic [3:0]             mtype;
    logic                   is_mgmt;

    assign mtype   = sym.data[31:28];
    assign is_mgmt = sym.valid && (sym.kind == lds_pkg::K_MGMT);

    always_comb begin
        next_state        = state;
        next_start_addr   = start_addr;
        next_flags        = '0;
        next_seg_error    = 1'b0;
        next_link_restart = 1'b0;
        if (rm_overflow_evt) begin
            // restart drops whatever packet was open
            next_flags.ovf    = 1'b1;
            next_link_restart = 1'b1;
            next_state        = lds_pkg::ST_IDLE;
        end else if (sym.valid) begin
            case (sym.kind)
                lds_pkg::K_SOW: begin
                    next_state      = lds_pkg::ST_PKT;
                    next_start_addr = sym.addr;
                end
                lds_pkg::K_DATA: begin
                    next_flags.msw = (state == lds_pkg::ST_IDLE);
                end
                lds_pkg::K_EOP: begin
                    if (state == lds_pkg::ST_IDLE) begin
                        next_flags.msw = 1'b1;
                    end else begin
                        next_flags.crc = !sym.crc_ok;
                        next_flags.adr = (sym.addr != start_addr);
                        next_seg_error = (sym.addr != start_addr);
                    end
                    next_state = lds_pkg::ST_IDLE;
                end
                lds_pkg::K_EBP: begin
                    next_flags.ebp = 1'b1;
                    next_state     = lds_pkg::ST_IDLE;
                end
                lds_pkg::K_MGMT: begin
                    next_flags.bip = (lds_pkg::lds_bip8(sym.data) != sym.chk);
                    next_flags.inv = (mtype > lds_pkg::MG_NACK);
                    next_flags.ufc = (mtype == lds_pkg::MG_FC) && !flow_en;
                    next_flags.uro = ((mtype == lds_pkg::MG_ACK) || (mtype == lds_pkg::MG_NACK))
                                     && !retry_en;
                end
                default: begin
                end
            endcase
        end
    end

    // flags rebuilt from zero every cycle, so each event gives one pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state        <= lds_pkg::ST_IDLE;
            start_addr   <= 8'h00;
            flags        <= '0;
            seg_error    <= 1'b0;
            link_restart <= 1'b0;
        end else begin
            state        <= next_state;
            start_addr   <= next_start_addr;
            flags        <= next_flags;
            seg_error    <= next_seg_error;
            link_restart <= next_link_restart;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_OVF_RESTART: assert property (rm_overflow_evt |=> flags.ovf && link_restart)
        else $error("overflow did not flag and restart");
    AST_EBP_FLAG: assert property (sym.valid && sym.kind == lds_pkg::K_EBP && !rm_overflow_evt
        |=> flags.ebp)
        else $error("bad packet end not flagged");
    AST_BIP_FLAG: assert property (is_mgmt && !rm_overflow_evt
        |=> flags.bip == (lds_pkg::lds_bip8($past(sym.data)) != $past(sym.chk)))
        else $error("parity flag wrong");
    AST_CRC_FLAG: assert property (sym.valid && sym.kind == lds_pkg::K_EOP && !sym.crc_ok
        && state == lds_pkg::ST_PKT && !rm_overflow_evt |=> flags.crc)
        else $error("checksum error not flagged");
    AST_UFC_FLAG: assert property (is_mgmt && mtype == lds_pkg::MG_FC && !flow_en
        && !rm_overflow_evt |=> flags.ufc)
        else $error("unexpected flow message not flagged");
    AST_URO_FLAG: assert property (flags.uro |-> $past(is_mgmt) && !$past(retry_en))
        else $error("retry flag without cause");
    AST_INV_FLAG: assert property (is_mgmt && mtype > lds_pkg::MG_NACK && !rm_overflow_evt
        |=> flags.inv)
        else $error("invalid packet not flagged");
    AST_MSW_FLAG: assert property (sym.valid && sym.kind == lds_pkg::K_DATA
        && state == lds_pkg::ST_IDLE && !rm_overflow_evt |=> flags.msw)
        else $error("missing start word not flagged");
    AST_ADR_SEG: assert property (flags.adr |-> seg_error)
        else $error("address conflict without segment error");
    AST_CRC_PULSE: assert property (flags.crc |=> !flags.crc)
        else $error("checksum flag longer than one cycle");

    COV_ADR: cover property (flags.adr);
    COV_EBP: cover property (flags.ebp);
    COV_PKT: cover property (sym.valid && sym.kind == lds_pkg::K_SOW ##[1:20] flags.crc);
endmodule

// ### lds_peer.sv
// far-side model of the transmit rate-match buffer feeding the block
module lds_peer (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  load,
    input  wire logic        tx_rd_req,
    output logic             tx_empty,
    output logic [31:0]      tx_data_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt;
    logic [7:0] seq;
    logic       pop;
    // an empty buffer shows inverted data, never a stale word that could pass for valid
    assign tx_empty   = (cnt == 8'h00);
    assign tx_data_in = tx_empty ? ~{24'hA00000, seq} : {24'hA00000, seq};
    assign pop        = tx_rd_req && !tx_empty;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 8'h00;
            seq <= 8'h00;
        end else begin
            cnt <= cnt + {4'h0, load} - {7'h00, pop};
            seq <= seq + {7'h00, pop};
        end
    end
endmodule

// ### link_diagnostic_flags_test.sv
// self-checking bench of the link diagnostic flag block
`include "lds_map.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module link_diagnostic_flags_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_b, reg_wr, reg_rd, irq, xcvr_ready, rsc, link_restart;
    logic tx_rd_req, tx_empty, tx_word_is_idle, rate_match_underflow;
    logic [3:0]  reg_addr, load;
    logic [31:0] reg_wdata, reg_rdata, tx_data_in, tx_word, rnd, v;
    logic [1:0]  rmo, ovf, ebp, bip, crc, ufc, uro, inv, msw, adr, seg;
    lds_pkg::lds_rx_sym_t rx_sym [2];
    int fails, num_checks;

    lds_top #(.NFUNC(2)) uut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .xcvr_ready(xcvr_ready), .reset_sequence_complete(rsc), .rx_sym(rx_sym),
        .rm_overflow_evt(rmo), .rate_match_overflow(ovf), .bad_packet_end_seen(ebp),
        .mgmt_parity_error(bip), .rx_checksum_error(crc), .unexpected_flow_msg(ufc),
        .unexpected_retry_msg(uro), .invalid_mgmt_packet(inv), .missing_start_word(msw),
        .addr_conflict(adr), .seg_error(seg), .link_restart(link_restart),
        .tx_rd_req(tx_rd_req), .tx_empty(tx_empty), .tx_data_in(tx_data_in),
        .tx_word(tx_word), .tx_word_is_idle(tx_word_is_idle),
        .rate_match_underflow(rate_match_underflow));
    lds_peer peer (.clk(clk), .rst_b(rst_b), .load(load), .tx_rd_req(tx_rd_req),
        .tx_empty(tx_empty), .tx_data_in(tx_data_in));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [7:0] par8(input logic [31:0] d);
        return d[31:24] ^ d[23:16] ^ d[15:8] ^ d[7:0];
    endfunction
    // flags of one function as {ovf,ebp,bip,crc,ufc,uro,inv,msw,adr,seg}
    function automatic logic [9:0] got(input int f);
        return {ovf[f], ebp[f], bip[f], crc[f], ufc[f], uro[f], inv[f], msw[f], adr[f], seg[f]};
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // one symbol (and optional overflow) into function f, flags one cycle later
    task automatic snd(input int f, input lds_pkg::lds_kind_t k, input logic [7:0] a,
                       input logic [31:0] d, input logic [7:0] c, input logic ok,
                       input logic ov, input logic [9:0] e);
        @(posedge clk);
        rx_sym[f] <= '{1'b1, k, a, d, c, ok};
        rmo[f] <= ov;
        @(posedge clk);
        rx_sym[f] <= '0;
        rmo[f] <= 1'b0;
        #1;
        `CHK(got(f), e)
        `CHK(got(1 - f), 10'h000)
        @(posedge clk);
        #1;
        `CHK(got(f), 10'h000)
        `CHK(link_restart, ov)
    endtask

    initial begin
        {rst_b, reg_wr, reg_rd, xcvr_ready, tx_rd_req, rmo} = '0;
        {reg_addr, load, reg_wdata} = '0;
        rx_sym[0] = '0;
        rx_sym[1] = '0;
        rnd = 32'hBF813701;
        repeat (2) @(posedge clk);
        `CHK({rsc, tx_word_is_idle, tx_word}, {2'b01, `LDS_IDLE_WORD})
        rst_b <= 1'b1;
        xcvr_ready <= 1'b1;
        for (int i = 0; i < 300 && rsc !== 1'b1; i++) @(posedge clk);
        `CHK(rsc, 1'b1)
        if (rsc !== 1'b1) test_done();
        rd(`LDS_OFF_EVT, v);
        `CHK(v, 32'h0000_0400)
        wr(`LDS_OFF_MASK, 32'h0000_0400);
        #1 `CHK(irq, 1'b1)
        wr(`LDS_OFF_EVT, 32'h0000_0400);
        #1 `CHK(irq, 1'b0)
        rd(4'h2, v);
        `CHK(v, 32'h0000_0000)
        // sequencer state done in bits 2:1, done flag in bit 0
        rd(`LDS_OFF_STAT, v);
        `CHK(v, 32'h0000_0005)
        $display("test reset and registers done");
        snd(1, lds_pkg::K_DATA, 8'h05, 32'h0, 8'h0, 1'b1, 1'b0, 10'h004);
        snd(0, lds_pkg::K_SOW, 8'h05, 32'h0, 8'h0, 1'b1, 1'b0, 10'h000);
        snd(0, lds_pkg::K_DATA, 8'h05, 32'h0, 8'h0, 1'b1, 1'b0, 10'h000);
        snd(0, lds_pkg::K_EOP, 8'h06, 32'h0, 8'h0, 1'b0, 1'b0, 10'h043);
        snd(1, lds_pkg::K_SOW, 8'h07, 32'h0, 8'h0, 1'b1, 1'b0, 10'h000);
        snd(1, lds_pkg::K_EBP, 8'h07, 32'h0, 8'h0, 1'b1, 1'b0, 10'h100);
        snd(0, lds_pkg::K_IDLE, 8'h00, 32'h0, 8'h0, 1'b1, 1'b1, 10'h200);
        $display("test receive framing done");
        for (int i = 0; i < 8; i++) begin
            logic [31:0] d;
            logic [7:0]  c;
            logic [3:0]  t;
            logic [9:0]  e;
            logic        fl;
            logic        re;
            rnd = lfsr(rnd);
            t = {2'b00, i[1:0]};
            if (i == 7) t = 4'hF;
            fl = i[2];
            re = i[2];
            d = {t, rnd[27:0]};
            c = rnd[28] ? par8(d) : ~par8(d);
            e = '0;
            e[7] = (c != par8(d));
            e[5] = (t == 4'h0) && !fl;
            e[4] = (t == 4'h1 || t == 4'h2) && !re;
            e[3] = (t > 4'h2);
            wr(`LDS_OFF_CTRL, {30'h0, re, fl});
            snd(i % 2, lds_pkg::K_MGMT, rnd[7:0], d, c, 1'b1, 1'b0, e);
        end
        rd(`LDS_OFF_CTRL, v);
        `CHK(v, 32'h0000_0003)
        $display("test management packets done");
        @(posedge clk);
        load <= 4'h2;
        @(posedge clk);
        load <= 4'h0;
        tx_rd_req <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            // the read at this edge is the empty one; stop reading after it
            if (i == 2) tx_rd_req <= 1'b0;
            #1;
            if (i < 2)
                `CHK({tx_word_is_idle, rate_match_underflow, tx_word}, {2'b00, 24'hA00000, i[7:0]})
            else
                `CHK({tx_word_is_idle, rate_match_underflow, tx_word}, {2'b11, `LDS_IDLE_WORD})
        end
        @(posedge clk);
        #1;
        `CHK({rate_match_underflow, link_restart, tx_word}, {2'b00, `LDS_IDLE_WORD})
        rd(`LDS_OFF_EVT, v);
        `CHK(v[1:0], 2'b11)
        $display("test transmit underflow done");
        // losing ready must drop the complete flag and rerun the sequence
        @(posedge clk);
        xcvr_ready <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        `CHK(rsc, 1'b0)
        @(posedge clk);
        xcvr_ready <= 1'b1;
        for (int i = 0; i < 300 && rsc !== 1'b1; i++) @(posedge clk);
        `CHK(rsc, 1'b1)
        $display("test transceiver ready loss done");
        test_done();
    end
endmodule
